// ==== common/amce_pkg.sv ====
// Notes on behaviour
// - ready_wait_input synchronised before any use
// - ready first sampled two cycles before strobe end, then every cycle while it stays low
// - each low ready cycle extends strobe one cycle
// - strobe ends one cycle after ready seen high
// - read selects valid read_setup_cycles before strobe low
// - read selects held read_hold_cycles after strobe high
// - write selects and data valid write_setup_cycles before
// - write selects and data held write_hold_cycles after
// - strobes change only on interface clock edges
// - phases counted in interface output clock periods
// - read data captured at read strobe rising edge
// - wide instance: 8 enables, address 22:3, 64 data
// - narrow instance: 2 enables, address 20:1, 16 data
// - three strobe pins used as output, read, write
// - timing counts per chip-select space from software
package amce_pkg;
  // ************************************************************
  // geometry of the wide and narrow instances (narrow overrides by parameter)
  // ************************************************************
  localparam int WIDE_DATA_W = 64;
  localparam int WIDE_BE_W = 8;
  localparam int WIDE_ADDR_HI = 22;
  localparam int WIDE_ADDR_LO = 3;
  localparam int NARROW_DATA_W = 16;
  localparam int NARROW_BE_W = 2;
  localparam int NARROW_ADDR_HI = 20;
  localparam int NARROW_ADDR_LO = 1;
  // ************************************************************
  // timing
  // ************************************************************
  localparam int CNT_W = 6;
  localparam int NUM_CS = 4;
  localparam int CS_IDX_W = 2;
  localparam int SYNC_STAGES = 3;
  // ready is looked at this many cycles before the strobe would end
  localparam logic [CNT_W-1:0] READY_LOOKAHEAD = 6'h02;
  localparam logic [CNT_W-1:0] CNT_ONE = 6'h01;
  localparam logic [CNT_W-1:0] CNT_ZERO = 6'h00;
  typedef enum logic [1:0] {
    AMCE_IDLE,
    AMCE_SETUP,
    AMCE_STROBE,
    AMCE_HOLD
  } amce_state_t;
endpackage : amce_pkg

// ==== dv/amce_engine_bench.sv ====
`timescale 1ns/1ps
module amce_engine_bench;
  // ************************************************************
  // stimulus and wiring
  // ************************************************************
  logic clk = 1'b0;
  logic reset_n = 1'b0;
  logic clk_en = 1'b1;
  logic req_valid = 1'b0;
  logic req_write = 1'b0;
  logic [1:0] req_cs = 2'h0;
  logic [22:3] req_addr = 20'h0;
  logic [7:0] req_be_n = 8'hFF;
  logic [63:0] req_wdata = 64'h0;
  logic [5:0] wait_cycles = 6'h00;
  logic [23:0] rs = {6'h04, 6'h03, 6'h02, 6'h00};
  logic [23:0] rt = {6'h08, 6'h06, 6'h04, 6'h02};
  logic [23:0] rh = {6'h01, 6'h00, 6'h03, 6'h02};
  logic [23:0] ws = {6'h01, 6'h02, 6'h03, 6'h00};
  logic [23:0] wt = {6'h02, 6'h05, 6'h03, 6'h01};
  logic [23:0] wh = {6'h03, 6'h01, 6'h00, 6'h02};
  logic req_ready, rsp_valid, data_bus_oe, output_enable_n;
  logic read_strobe_n, write_strobe_n, ready_wait_input;
  logic [63:0] rsp_rdata, data_bus_out, data_bus_in;
  logic [3:0] chip_select_n;
  logic [7:0] byte_enable_n;
  logic [22:3] address_bus;
  int miscompares = 0;
  int total_checks = 0;
  always #4 clk = ~clk;
  amce_engine amce_engine_i (.clk(clk), .reset_n(reset_n), .clk_en(clk_en),
    .read_setup_cycles(rs), .read_strobe_len(rt), .read_hold_cycles(rh),
    .write_setup_cycles(ws), .write_strobe_len(wt),
    .write_hold_cycles(wh), .req_valid(req_valid), .req_write(req_write),
    .req_cs(req_cs), .req_addr(req_addr), .req_be_n(req_be_n),
    .req_wdata(req_wdata), .req_ready(req_ready), .rsp_valid(rsp_valid),
    .rsp_rdata(rsp_rdata), .chip_select_n(chip_select_n),
    .byte_enable_n(byte_enable_n), .address_bus(address_bus),
    .data_bus_out(data_bus_out), .data_bus_oe(data_bus_oe),
    .data_bus_in(data_bus_in), .output_enable_n(output_enable_n),
    .read_strobe_n(read_strobe_n), .write_strobe_n(write_strobe_n),
    .ready_wait_input(ready_wait_input));
  amce_mem_model amce_mem_model_i (.clk(clk), .address_bus(address_bus),
    .data_bus_out(data_bus_out), .data_bus_oe(data_bus_oe),
    .data_bus_in(data_bus_in), .output_enable_n(output_enable_n),
    .read_strobe_n(read_strobe_n), .write_strobe_n(write_strobe_n),
    .ready_wait_input(ready_wait_input), .wait_cycles(wait_cycles));
  // ************************************************************
  // helpers
  // ************************************************************
  function automatic int fld(input logic [23:0] v, input int cs);
    int f;
    f = int'(v[cs*6 +: 6]);
    return (f == 0) ? 1 : f;
  endfunction : fld
  task automatic check(input bit ok, input string msg);
    total_checks++;
    if (!ok) begin
      miscompares++;
      $display("mismatch %0t %s", $time, msg);
    end
  endtask : check
  task automatic access(input logic w, input logic [1:0] cs,
    input logic [22:3] a, input logic [63:0] d, input logic [5:0] wc,
    output int su, output int st, output int ho, output logic [63:0] rd);
    int n;
    logic s;
    logic [7:0] be;
    be = w ? 8'hC3 : 8'h00;
    su = 0;
    st = 0;
    ho = 0;
    rd = 64'h0;
    @(posedge clk);
    req_valid <= 1'b1;
    req_write <= w;
    req_cs <= cs;
    req_addr <= a;
    req_be_n <= be;
    req_wdata <= d;
    wait_cycles <= wc;
    for (n = 0; n < 200; n++) begin
      @(posedge clk);
      req_valid <= 1'b0;
      #1;
      if (rsp_valid === 1'b1) rd = rsp_rdata;
      if (chip_select_n === 4'hF) break;
      s = w ? write_strobe_n : read_strobe_n;
      if (s === 1'b0) st++;
      else if (st == 0) su++;
      else ho++;
      check(chip_select_n === ~(4'h1 << cs) && address_bus === a &&
        byte_enable_n === be && output_enable_n === w, "selects");
      check((w ? read_strobe_n : write_strobe_n) === 1'b1, "strobe");
      check(req_ready === 1'b0, "ready during access");
      if (w) check(data_bus_oe === 1'b1 && data_bus_out === d, "wdata");
    end
    check(n < 200, "access hung");
    check(req_ready === 1'b1, "ready after access");
  endtask : access
  // ************************************************************
  // scenarios
  // ************************************************************
  task automatic t_all_spaces;
    int su, st, ho;
    logic [63:0] rd, d;
    for (int cs = 0; cs < 4; cs++) begin
      d = 64'h0123_4567_89AB_CDE0 | 64'(cs);
      access(1'b1, 2'(cs), 20'h12340 + 20'(cs), d, 6'h00, su, st, ho, rd);
      check(su == fld(ws, cs) && ho == fld(wh, cs), "write phases");
      check(st == fld(wt, cs), "write strobe");
      access(1'b0, 2'(cs), 20'h12340 + 20'(cs), 64'h0, 6'h00, su, st, ho,
        rd);
      check(su == fld(rs, cs) && ho == fld(rh, cs), "read phases");
      check(st == fld(rt, cs), "read strobe");
      check(rd === d, "read data");
    end
  endtask : t_all_spaces
  task automatic t_ready;
    int su, st, ho;
    logic [63:0] rd;
    access(1'b0, 2'h3, 20'h12343, 64'h0, 6'h02, su, st, ho, rd);
    check(st == 8, "early ready ignored");
    access(1'b0, 2'h3, 20'h12343, 64'h0, 6'h0A, su, st, ho, rd);
    check(st > 8 && st <= 18, "strobe stretch");
    check(rd === 64'h0123_4567_89AB_CDE3, "stretched data");
  endtask : t_ready
  task automatic t_freeze;
    @(posedge clk);
    clk_en <= 1'b0;
    req_valid <= 1'b1;
    repeat (3) begin
      @(posedge clk);
      #1;
      check(chip_select_n === 4'hF && req_ready === 1'b1, "frozen");
    end
    @(posedge clk);
    clk_en <= 1'b1;
    req_valid <= 1'b0;
    @(posedge clk);
    #1;
    check(chip_select_n === 4'hF && read_strobe_n === 1'b1, "thaw");
  endtask : t_freeze
  task finish_test;
    if (miscompares == 0 && total_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : finish_test
  initial begin
    #200000;
    miscompares++;
    finish_test();
  end
  initial begin
    repeat (12) @(posedge clk);
    reset_n <= 1'b1;
    @(posedge clk);
    #1;
    check(chip_select_n === 4'hF && read_strobe_n === 1'b1 &&
      write_strobe_n === 1'b1 && data_bus_oe === 1'b0, "idle");
    check(req_ready === 1'b1 && rsp_valid === 1'b0, "idle ready");
    t_all_spaces();
    t_ready();
    t_freeze();
    finish_test();
  end
endmodule : amce_engine_bench

// ==== dv/amce_mem_model.sv ====
`timescale 1ns/1ps
module amce_mem_model (
  // clock
  input wire logic clk,
  // memory pins
  input wire logic [22:3] address_bus,
  input wire logic [63:0] data_bus_out,
  input wire logic data_bus_oe,
  output logic [63:0] data_bus_in,
  input wire logic output_enable_n,
  input wire logic read_strobe_n,
  input wire logic write_strobe_n,
  output logic ready_wait_input,
  // scenario control
  input wire logic [5:0] wait_cycles
);
  // ************************************************************
  // word store and ready pacing
  // ************************************************************
  logic [63:0] mem_r [16];
  logic [63:0] last_r = 64'h0;
  logic [5:0] cnt_r = 6'h00;
  always_ff @(posedge clk) begin
    cnt_r <= (read_strobe_n && write_strobe_n) ? 6'h00 : cnt_r + 6'h01;
    if (!output_enable_n) last_r <= mem_r[address_bus[6:3]];
  end
  // write data taken as the write strobe rises
  always @(posedge write_strobe_n) begin
    if (data_bus_oe) mem_r[address_bus[6:3]] = data_bus_out;
  end
  // released bus shows the inverse of the last word
  assign data_bus_in = output_enable_n ? ~last_r : mem_r[address_bus[6:3]];
  // ready held low whole cycles from strobe start
  assign ready_wait_input = (read_strobe_n && write_strobe_n) ||
    cnt_r >= wait_cycles;
endmodule : amce_mem_model

// ==== src/amce_engine.sv ====
`timescale 1ns/1ps
module amce_engine #(
  parameter int DATA_W = amce_pkg::WIDE_DATA_W,
  parameter int BE_W = amce_pkg::WIDE_BE_W,
  parameter int ADDR_HI = amce_pkg::WIDE_ADDR_HI,
  parameter int ADDR_LO = amce_pkg::WIDE_ADDR_LO,
  parameter int NUM_CS = amce_pkg::NUM_CS,
  parameter int CNT_W = amce_pkg::CNT_W
) (
  // clock and reset
  input wire logic clk,
  input wire logic reset_n,
  input wire logic clk_en,
  // per chip-select timing, packed one field per space
  input wire logic [NUM_CS*CNT_W-1:0] read_setup_cycles,
  input wire logic [NUM_CS*CNT_W-1:0] read_strobe_len,
  input wire logic [NUM_CS*CNT_W-1:0] read_hold_cycles,
  input wire logic [NUM_CS*CNT_W-1:0] write_setup_cycles,
  input wire logic [NUM_CS*CNT_W-1:0] write_strobe_len,
  input wire logic [NUM_CS*CNT_W-1:0] write_hold_cycles,
  // request side
  input wire logic req_valid,
  input wire logic req_write,
  input wire logic [amce_pkg::CS_IDX_W-1:0] req_cs,
  input wire logic [ADDR_HI:ADDR_LO] req_addr,
  input wire logic [BE_W-1:0] req_be_n,
  input wire logic [DATA_W-1:0] req_wdata,
  output logic req_ready,
  output logic rsp_valid,
  output logic [DATA_W-1:0] rsp_rdata,
  // memory pins
  output logic [NUM_CS-1:0] chip_select_n,
  output logic [BE_W-1:0] byte_enable_n,
  output logic [ADDR_HI:ADDR_LO] address_bus,
  output logic [DATA_W-1:0] data_bus_out,
  output logic data_bus_oe,
  input wire logic [DATA_W-1:0] data_bus_in,
  output logic output_enable_n,
  output logic read_strobe_n,
  output logic write_strobe_n,
  input wire logic ready_wait_input
);
  // ************************************************************
  // declarations
  // ************************************************************
  amce_pkg::amce_state_t state_r;
  logic [CNT_W-1:0] cnt_r;
  logic is_write_r;
  logic [amce_pkg::CS_IDX_W-1:0] cs_r;
  logic ready_lvl;
  logic wait_seen_r;
  logic [1:0] tail_r;

  function automatic logic [CNT_W-1:0] pick(
    input logic [NUM_CS*CNT_W-1:0] vec,
    input logic [amce_pkg::CS_IDX_W-1:0] idx);
    logic [CNT_W-1:0] v;
    v = vec[idx*CNT_W +: CNT_W];
    pick = (v == amce_pkg::CNT_ZERO) ? amce_pkg::CNT_ONE : v;
  endfunction : pick

  amce_ready_sync u_sync (
    .clk(clk),
    .reset_n(reset_n),
    .clk_en(clk_en),
    .pin_in(ready_wait_input),
    .level_out(ready_lvl)
  );

  // ************************************************************
  // phase sequencer
  // ************************************************************
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      state_r <= amce_pkg::AMCE_IDLE;
      cnt_r <= amce_pkg::CNT_ZERO;
      is_write_r <= 1'b0;
      cs_r <= '0;
      wait_seen_r <= 1'b0;
      tail_r <= 2'h0;
    end else if (clk_en) begin
      unique case (state_r)
        amce_pkg::AMCE_IDLE: begin
          if (req_valid) begin
            is_write_r <= req_write;
            cs_r <= req_cs;
            state_r <= amce_pkg::AMCE_SETUP;
            cnt_r <= req_write ? pick(write_setup_cycles, req_cs)
                               : pick(read_setup_cycles, req_cs);
          end
        end
        amce_pkg::AMCE_SETUP: begin
          if (cnt_r == amce_pkg::CNT_ONE) begin
            state_r <= amce_pkg::AMCE_STROBE;
            wait_seen_r <= 1'b0;
            tail_r <= 2'h0;
            cnt_r <= is_write_r ? pick(write_strobe_len, cs_r)
                                : pick(read_strobe_len, cs_r);
          end else begin
            cnt_r <= cnt_r - amce_pkg::CNT_ONE;
          end
        end
        amce_pkg::AMCE_STROBE: begin
          if (tail_r != 2'h0) begin
            // counting out the one cycle after ready came back
            if (tail_r == 2'h1) begin
              state_r <= amce_pkg::AMCE_HOLD;
              cnt_r <= is_write_r ? pick(write_hold_cycles, cs_r)
                                  : pick(read_hold_cycles, cs_r);
            end
            tail_r <= tail_r - 2'h1;
          end else if (wait_seen_r) begin
            if (ready_lvl) begin
              tail_r <= 2'h1;
            end
          end else if (cnt_r == amce_pkg::READY_LOOKAHEAD && !ready_lvl)
          begin
            wait_seen_r <= 1'b1;
          end else if (cnt_r == amce_pkg::CNT_ONE) begin
            state_r <= amce_pkg::AMCE_HOLD;
            cnt_r <= is_write_r ? pick(write_hold_cycles, cs_r)
                                : pick(read_hold_cycles, cs_r);
          end else begin
            cnt_r <= cnt_r - amce_pkg::CNT_ONE;
          end
        end
        amce_pkg::AMCE_HOLD: begin
          if (cnt_r == amce_pkg::CNT_ONE) begin
            state_r <= amce_pkg::AMCE_IDLE;
          end else begin
            cnt_r <= cnt_r - amce_pkg::CNT_ONE;
          end
        end
      endcase
    end
  end

  // ************************************************************
  // pins
  // ************************************************************
  logic starting;
  logic going_strobe;
  logic leaving_strobe;
  logic ending;
  assign starting = (state_r == amce_pkg::AMCE_IDLE) && req_valid;
  assign going_strobe = (state_r == amce_pkg::AMCE_SETUP) &&
                        (cnt_r == amce_pkg::CNT_ONE);
  assign leaving_strobe = (state_r == amce_pkg::AMCE_STROBE) &&
    ((tail_r == 2'h1) ||
     (tail_r == 2'h0 && !wait_seen_r && cnt_r == amce_pkg::CNT_ONE &&
      !(cnt_r == amce_pkg::READY_LOOKAHEAD)));
  assign ending = (state_r == amce_pkg::AMCE_HOLD) &&
                  (cnt_r == amce_pkg::CNT_ONE);

  // selects stand from setup start to hold end
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      chip_select_n <= '1;
      byte_enable_n <= '1;
      address_bus <= '0;
      data_bus_out <= '0;
      data_bus_oe <= 1'b0;
      output_enable_n <= 1'b1;
    end else if (clk_en) begin
      if (starting) begin
        chip_select_n <= ~(NUM_CS'(1) << req_cs);
        byte_enable_n <= req_be_n;
        address_bus <= req_addr;
        data_bus_out <= req_wdata;
        data_bus_oe <= req_write;
        output_enable_n <= req_write;
      end else if (ending) begin
        chip_select_n <= '1;
        byte_enable_n <= '1;
        data_bus_oe <= 1'b0;
        output_enable_n <= 1'b1;
      end
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      read_strobe_n <= 1'b1;
      write_strobe_n <= 1'b1;
    end else if (clk_en) begin
      if (going_strobe) begin
        read_strobe_n <= is_write_r;
        write_strobe_n <= !is_write_r;
      end else if (leaving_strobe) begin
        read_strobe_n <= 1'b1;
        write_strobe_n <= 1'b1;
      end
    end
  end

  // data sampled at the edge that raises the read strobe
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      rsp_valid <= 1'b0;
      rsp_rdata <= '0;
    end else if (clk_en) begin
      rsp_valid <= leaving_strobe && !is_write_r;
      if (leaving_strobe && !is_write_r) begin
        rsp_rdata <= data_bus_in;
      end
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      req_ready <= 1'b0;
    end else if (clk_en) begin
      req_ready <= (state_r == amce_pkg::AMCE_IDLE) ? !req_valid : ending;
    end
  end

  // ************************************************************
  // checks
  // ************************************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);

  sequence s_strobe_low;
    !read_strobe_n || !write_strobe_n;
  endsequence

  a_strobe_one_hot: assert property (
    !(!read_strobe_n && !write_strobe_n))
    else $error("both strobes low");
  a_select_during_strobe: assert property (
    s_strobe_low |-> (chip_select_n != '1))
    else $error("strobe without chip select");
  a_oe_write: assert property (
    !write_strobe_n |-> output_enable_n && data_bus_oe)
    else $error("write strobe with output enable");
  a_read_capture: assert property (
    clk_en && $rose(read_strobe_n) |-> rsp_valid)
    else $error("read data not captured");
  a_hold_after: assert property (
    clk_en && $rose(read_strobe_n) |-> chip_select_n != '1)
    else $error("select dropped with strobe");
  a_wdata_stable: assert property (
    !write_strobe_n && clk_en |=> $stable(data_bus_out))
    else $error("write data moved under strobe");
  a_no_overlap: assert property (
    (state_r != amce_pkg::AMCE_IDLE) |-> !req_ready ||
    (state_r == amce_pkg::AMCE_HOLD))
    else $error("request accepted mid access");
  a_wait_extends: assert property (
    (clk_en && wait_seen_r && !ready_lvl && tail_r == 2'h0) and
      s_strobe_low |=>
      (!clk_en || ($stable(read_strobe_n) && $stable(write_strobe_n))))
    else $error("strobe ended while waiting");
endmodule : amce_engine

// ==== src/amce_ready_sync.sv ====
`timescale 1ns/1ps
module amce_ready_sync (
  // clock and reset
  input wire logic clk,
  input wire logic reset_n,
  input wire logic clk_en,
  // pin and filtered level
  input wire logic pin_in,
  output logic level_out
);
  logic [amce_pkg::SYNC_STAGES-1:0] sync_r;

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      sync_r <= 3'h7;
    end else if (clk_en) begin
      sync_r <= {sync_r[1:0], pin_in};
    end
  end

  // level accepted once second and third stages agree
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      level_out <= 1'b1;
    end else if (clk_en && (sync_r[1] == sync_r[2])) begin
      level_out <= sync_r[2];
    end
  end
endmodule : amce_ready_sync
